// ---- core/adc_cmd_pkg.sv ----
package adc_cmd_pkg;
  // Clock and link timing
  localparam int CLK_KHZ = 25000;
  localparam int MOD_KHZ_NORMAL = 256;
  localparam int MOD_KHZ_TURBO = 512;
  localparam int TIMEOUT_MOD_NORMAL = 32760;
  localparam int TIMEOUT_MOD_TURBO = 65520;
  // Longest idle time, rounded down to whole clock cycles
  localparam int TIMEOUT_CYC_NORMAL =
    TIMEOUT_MOD_NORMAL * CLK_KHZ / MOD_KHZ_NORMAL;
  localparam int TIMEOUT_CYC_TURBO =
    TIMEOUT_MOD_TURBO * CLK_KHZ / MOD_KHZ_TURBO;
  localparam int TIMEOUT_W = 22;
  localparam int BAUD_W = 16;

  // Result format
  localparam int RES_W = 24;
  localparam logic [23:0] RES_POS_MAX = 24'h7FFFFF;
  localparam logic [23:0] RES_NEG_MIN = 24'h800000;

  // Command bytes and sync word
  localparam logic [7:0] SYNC_BYTE = 8'h55;
  localparam logic [6:0] CMD_RESET = 7'h03;
  localparam logic [6:0] CMD_START = 7'h04;
  localparam logic [6:0] CMD_SLEEP = 7'h01;
  localparam logic [3:0] CMD_RDATA = 4'h1;
  localparam logic [3:0] CMD_REG_READ_CMD = 4'h2;
  localparam logic [3:0] CMD_REG_WRITE_CMD = 4'h4;

  // Register map
  localparam int REG_COUNT = 5;
  localparam logic [2:0] REG_ADDR_MAX = 3'h4;
  localparam logic [2:0] REG_CFG1 = 3'h1;
  localparam logic [2:0] REG_CFG2 = 3'h2;
  localparam logic [2:0] REG_CFG3 = 3'h3;
  localparam logic [2:0] REG_GPIO = 3'h4;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] REG_UNMAPPED = 8'h00;
  localparam int MODE_BIT = 4;
  localparam int CM_BIT = 3;
  localparam int READY_BIT = 7;
  localparam int DCNT_BIT = 6;
  localparam int INTEG_LSB = 4;
  localparam int AUTO_BIT = 0;
  localparam int PIN2_DIR_BIT = 6;
  localparam int PIN2_SEL_BIT = 3;
  localparam int PIN2_DAT_BIT = 2;
  localparam logic [1:0] INTEG_INV = 2'b01;
  localparam logic [1:0] INTEG_CRC = 2'b10;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_START = 2'b01, RX_BITS = 2'b10, RX_STOP = 2'b11
  } rx_state_type;

  typedef enum logic [1:0] {
    PH_SYNC = 2'b00, PH_CMD = 2'b01, PH_WDATA = 2'b10
  } phase_type;

  typedef enum logic [1:0] {
    RK_NONE = 2'b00, RK_DATA = 2'b01, RK_REG = 2'b10
  } resp_kind_type;
endpackage

// ---- core/byte_stream_if.sv ----
`timescale 1ns/1ps
interface byte_stream_if #(parameter int W = 8) ();
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// ---- core/byte_fifo.sv ----
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = adc_cmd_pkg::FIFO_DEPTH
) (
  // Clock and control
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic en_in,
  // Streams
  byte_stream_if.snk wr,
  byte_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  wire push = wr.valid && wr.ready;
  wire pop = rd.valid && rd.ready;

  // Full and empty straight from the fill count
  assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_q != '0);
  assign rd.data = mem_q[rp_q];

  // Storage carries no reset: only valid words are ever read
  always_ff @(posedge clk_in) begin
    if (en_in && push) begin
      mem_q[wp_q] <= wr.data;
    end
  end

  // Pointers wrap at DEPTH so depths need not be powers of two
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (en_in) begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ---- core/adc_uart_command_engine.sv ----
`timescale 1ns/1ps
module adc_uart_command_engine #(
  parameter int RAW_W = 26,
  parameter int TIMEOUT_NORMAL = adc_cmd_pkg::TIMEOUT_CYC_NORMAL,
  parameter int TIMEOUT_TURBO = adc_cmd_pkg::TIMEOUT_CYC_TURBO
) (
  // Clock, reset, enable
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // Serial pins
  input wire logic rx_in,
  output logic tx_out,
  // Converter side
  input wire logic conv_done_in,
  input wire logic signed [RAW_W-1:0] conv_data_in,
  output logic conv_start_out,
  output logic analog_on_out,
  output logic idac_on_out,
  // Configuration and status
  output logic [8*adc_cmd_pkg::REG_COUNT-1:0] cfg_out,
  output logic result_ready_out,
  output logic pin2_out,
  output logic pin2_oe_out
);
  import adc_cmd_pkg::*;

  // Saturate the filter output into the 24-bit code range
  function automatic logic [23:0] clip(input logic signed [RAW_W-1:0] v);
    if (v > $signed({{(RAW_W-RES_W){1'b0}}, RES_POS_MAX})) begin
      clip = RES_POS_MAX;
    end else if (v < $signed({{(RAW_W-RES_W){1'b1}}, RES_NEG_MIN})) begin
      clip = RES_NEG_MIN;
    end else begin
      clip = v[RES_W-1:0];
    end
  endfunction

  // CRC16 over the first n payload bytes, first byte first
  function automatic logic [15:0] crc16(input logic [7:0] b [4],
                                        input logic [2:0] n);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 0; i < 4; i++) begin
      if (3'(i) < n) begin
        c = c ^ {b[i], 8'h00};
        for (int k = 0; k < 8; k++) begin
          c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
      end
    end
    crc16 = c;
  endfunction

  logic rx_m_q, rx_s_q, rx_p_q, soft_rst_q;
  rx_state_type rx_st_q;
  phase_type phase_q;
  logic [BAUD_W-1:0] bit_len_q, cnt_q;
  logic [2:0] bit_idx_q, wr_addr_q;
  logic [7:0] rx_sh_q;
  logic rx_stb_q;
  logic [TIMEOUT_W-1:0] idle_q;
  logic [7:0] cfg_q [REG_COUNT];
  logic converting_q, sleep_q, sleep_pend_q, conv_start_q;
  logic [23:0] res_q, hold_res_q;
  logic [7:0] conv_cnt_q, hold_cnt_q;
  logic ready_q, data_req_q, reg_req_q;
  logic [7:0] reg_byte_q;
  resp_kind_type kind_q;
  logic [3:0] idx_q;
  logic tx_busy_q, tx_q;
  logic [9:0] tx_sh_q;
  logic [3:0] tx_bits_q;
  logic [BAUD_W-1:0] tx_cnt_q;
  logic pin2_q, pin2_oe_q, analog_q;

  byte_stream_if #(.W(8)) to_fifo ();
  byte_stream_if #(.W(8)) from_fifo ();

  // Reset command takes the same path as the pin reset
  wire rst_all = reset_in || soft_rst_q;
  wire rx_edge = rx_s_q ^ rx_p_q;
  wire rx_fall = rx_p_q && !rx_s_q;
  wire turbo = cfg_q[REG_CFG1][MODE_BIT];
  wire cont = cfg_q[REG_CFG1][CM_BIT];
  wire auto_mode = cfg_q[REG_CFG3][AUTO_BIT];
  wire dcnt_on = cfg_q[REG_CFG2][DCNT_BIT];
  wire [1:0] integ = cfg_q[REG_CFG2][INTEG_LSB+1:INTEG_LSB];
  wire [BAUD_W-1:0] half_len = bit_len_q >> 1;
  wire [TIMEOUT_W-1:0] idle_lim =
    turbo ? TIMEOUT_W'(TIMEOUT_TURBO - 1) : TIMEOUT_W'(TIMEOUT_NORMAL - 1);
  wire timeout_hit = clk_en_in && (idle_q == idle_lim);

  // Command decode, only on a byte latched in the command phase
  wire cmd_stb = rx_stb_q && (phase_q == PH_CMD);
  wire is_reset = cmd_stb && (rx_sh_q[7:1] == CMD_RESET);
  wire is_start = cmd_stb && (rx_sh_q[7:1] == CMD_START);
  wire is_sleep = cmd_stb && (rx_sh_q[7:1] == CMD_SLEEP);
  wire is_rdata = cmd_stb && (rx_sh_q[7:4] == CMD_RDATA);
  wire is_reg_read_cmd = cmd_stb && (rx_sh_q[7:4] == CMD_REG_READ_CMD);
  wire is_reg_write_cmd = cmd_stb && (rx_sh_q[7:4] == CMD_REG_WRITE_CMD);
  wire [2:0] cmd_addr = rx_sh_q[3:1];
  wire wr_commit = rx_stb_q && (phase_q == PH_WDATA)
                   && (wr_addr_q <= REG_ADDR_MAX);
  wire wr_restart = wr_commit && (wr_addr_q != REG_GPIO)
                    && converting_q;
  wire start_now = is_start || wr_restart;
  wire [23:0] clipped = clip(conv_data_in);

  // Response framing
  wire [2:0] npay = dcnt_on ? 3'd4 : 3'd3;
  wire resp_busy = (kind_q != RK_NONE);
  logic [7:0] pay [4];
  logic [15:0] crc_val;
  logic [3:0] resp_len;
  logic [7:0] cur_byte;
  logic [2:0] inv_idx;
  assign pay[0] = dcnt_on ? hold_cnt_q : hold_res_q[7:0];
  assign pay[1] = dcnt_on ? hold_res_q[7:0] : hold_res_q[15:8];
  assign pay[2] = dcnt_on ? hold_res_q[15:8] : hold_res_q[23:16];
  assign pay[3] = dcnt_on ? hold_res_q[23:16] : 8'h00;
  assign crc_val = crc16(pay, npay);
  assign inv_idx = idx_q[2:0] - npay;
  assign resp_len = (kind_q == RK_REG) ? 4'd1 :
                    (integ == INTEG_CRC) ? {1'b0, npay} + 4'd2 :
                    (integ == INTEG_INV) ? {npay, 1'b0} :
                    {1'b0, npay};
  assign cur_byte = (kind_q == RK_REG) ? hold_res_q[7:0] :
                    (idx_q < {1'b0, npay}) ? pay[idx_q[1:0]] :
                    (integ == INTEG_INV) ? ~pay[inv_idx[1:0]] :
                    (idx_q == {1'b0, npay}) ? crc_val[15:8] :
                    crc_val[7:0];
  assign to_fifo.valid = resp_busy;
  assign to_fifo.data = cur_byte;
  assign from_fifo.ready = !tx_busy_q; // Drain stalls while a frame is out

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) tx_fifo (
    .clk_in(mclk_in),
    .rst_in(rst_all),
    .en_in(clk_en_in),
    .wr(to_fifo.snk),
    .rd(from_fifo.src)
  );

  // Pin synchroniser; the first stage feeds only the second
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
      rx_p_q <= 1'b1;
      soft_rst_q <= 1'b0;
    end else if (clk_en_in) begin
      rx_m_q <= rx_in;
      rx_s_q <= rx_m_q;
      rx_p_q <= rx_s_q;
      soft_rst_q <= is_reset;
    end
  end

  // Receiver: the sync start bit measures the baud, others are sampled
  always_ff @(posedge mclk_in) begin
    if (rst_all || clk_en_in) rx_stb_q <= 1'b0;
    if (rst_all || timeout_hit) begin
      rx_st_q <= RX_IDLE;
      cnt_q <= '0;
      bit_idx_q <= '0;
      rx_sh_q <= '0;
      if (rst_all) begin
        bit_len_q <= '1;
      end
    end else if (clk_en_in) begin
      cnt_q <= cnt_q - 1'b1;
      case (rx_st_q)
        RX_IDLE: begin
          bit_idx_q <= '0;
          if (rx_fall && phase_q == PH_SYNC) begin
            cnt_q <= '0;
            rx_st_q <= RX_START;
          end else if (rx_fall) begin
            cnt_q <= bit_len_q + half_len - 1'b1;
            rx_st_q <= RX_BITS;
          end
        end
        RX_START: begin
          cnt_q <= cnt_q + 1'b1;
          if (rx_s_q) begin
            bit_len_q <= cnt_q + 1'b1;
            cnt_q <= (cnt_q + 1'b1) >> 1;
            rx_st_q <= RX_BITS;
          end
        end
        RX_BITS: begin
          if (cnt_q == '0) begin
            rx_sh_q <= {rx_s_q, rx_sh_q[7:1]};
            bit_idx_q <= bit_idx_q + 1'b1;
            cnt_q <= bit_len_q - 1'b1;
            if (bit_idx_q == 3'd7) begin
              rx_st_q <= RX_STOP;
            end
          end
        end
        default: begin
          if (cnt_q == '0) begin
            rx_stb_q <= rx_s_q;
            rx_st_q <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // Protocol phase and idle timeout
  always_ff @(posedge mclk_in) begin
    if (rst_all || timeout_hit) begin
      phase_q <= PH_SYNC;
      idle_q <= '0;
      wr_addr_q <= '0;
    end else if (clk_en_in) begin
      idle_q <= (rx_edge || (phase_q == PH_SYNC && rx_st_q == RX_IDLE))
                ? '0 : idle_q + 1'b1;
      if (rx_stb_q) begin
        case (phase_q)
          PH_SYNC: phase_q <= (rx_sh_q == SYNC_BYTE) ? PH_CMD : PH_SYNC;
          PH_CMD: begin
            wr_addr_q <= cmd_addr;
            phase_q <= is_reg_write_cmd ? PH_WDATA : PH_SYNC;
          end
          default: phase_q <= PH_SYNC;
        endcase
      end
    end
  end

  // Register file; writes store all eight bits, but reads of the ready bit return the status flag
  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        cfg_q[i] <= REG_RESET;
      end
    end else if (clk_en_in && wr_commit) begin
      cfg_q[wr_addr_q] <= rx_sh_q;
    end
  end

  // Conversion sequencing and power-down
  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      converting_q <= 1'b0;
      sleep_q <= 1'b0;
      sleep_pend_q <= 1'b0;
      conv_start_q <= 1'b0;
    end else if (clk_en_in) begin
      conv_start_q <= start_now;
      if (start_now) begin
        converting_q <= 1'b1;
        sleep_q <= 1'b0;
        sleep_pend_q <= 1'b0;
      end else if (is_sleep && converting_q && !conv_done_in) begin
        sleep_pend_q <= 1'b1;
      end else if (is_sleep) begin
        sleep_q <= 1'b1;
        converting_q <= 1'b0;
      end else if (conv_done_in && (!cont || sleep_pend_q)) begin
        converting_q <= 1'b0;
        sleep_q <= sleep_pend_q;
        sleep_pend_q <= 1'b0;
      end
    end
  end

  // Results, counter, ready flag and response requests
  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      res_q <= '0;
      conv_cnt_q <= '0;
      ready_q <= 1'b0;
      data_req_q <= 1'b0;
      reg_req_q <= 1'b0;
      reg_byte_q <= '0;
    end else if (clk_en_in) begin
      if (conv_done_in) begin
        res_q <= clipped;
        conv_cnt_q <= conv_cnt_q + 1'b1;
      end
      // A new result wins over the clear from a load
      if (conv_done_in) begin
        ready_q <= 1'b1;
      end else if (data_req_q && !resp_busy) begin
        ready_q <= 1'b0;
      end
      if (is_rdata || (conv_done_in && auto_mode)) begin
        data_req_q <= 1'b1;
      end else if (!resp_busy) begin
        data_req_q <= 1'b0;
      end
      if (is_reg_read_cmd) begin
        reg_req_q <= 1'b1;
        reg_byte_q <= (cmd_addr > REG_ADDR_MAX) ? REG_UNMAPPED :
          (cmd_addr == REG_CFG2) ?
          {ready_q, cfg_q[REG_CFG2][6:0]} : cfg_q[cmd_addr];
      end else if (!resp_busy && !data_req_q) begin
        reg_req_q <= 1'b0;
      end
    end
  end

  // Response sequencer; held values never change mid-frame
  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      kind_q <= RK_NONE;
      idx_q <= '0;
      hold_res_q <= '0;
      hold_cnt_q <= '0;
    end else if (clk_en_in) begin
      if (!resp_busy && data_req_q) begin
        kind_q <= RK_DATA;
        idx_q <= '0;
        hold_res_q <= res_q;
        hold_cnt_q <= conv_cnt_q;
      end else if (!resp_busy && reg_req_q) begin
        kind_q <= RK_REG;
        idx_q <= '0;
        hold_res_q <= {16'h0000, reg_byte_q};
      end else if (resp_busy && to_fifo.ready) begin
        idx_q <= idx_q + 1'b1;
        if (idx_q == resp_len - 1'b1) begin
          kind_q <= RK_NONE;
        end
      end
    end
  end

  // Transmitter: start, eight data bits LSB first, stop
  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      tx_busy_q <= 1'b0;
      tx_sh_q <= '1;
      tx_bits_q <= '0;
      tx_cnt_q <= '0;
      tx_q <= 1'b1;
    end else if (clk_en_in) begin
      tx_q <= tx_busy_q ? tx_sh_q[0] : 1'b1;
      if (!tx_busy_q && from_fifo.valid) begin
        tx_busy_q <= 1'b1;
        tx_sh_q <= {1'b1, from_fifo.data, 1'b0};
        tx_bits_q <= '0;
        tx_cnt_q <= bit_len_q - 1'b1;
      end else if (tx_busy_q && tx_cnt_q == '0) begin
        tx_sh_q <= {1'b1, tx_sh_q[9:1]};
        tx_bits_q <= tx_bits_q + 1'b1;
        tx_cnt_q <= bit_len_q - 1'b1;
        tx_busy_q <= (tx_bits_q != 4'd9);
      end else if (tx_busy_q) begin
        tx_cnt_q <= tx_cnt_q - 1'b1;
      end
    end
  end

  // Registered pin and power outputs
  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      pin2_q <= 1'b0;
      pin2_oe_q <= 1'b0;
      analog_q <= 1'b1;
    end else if (clk_en_in) begin
      pin2_oe_q <= cfg_q[REG_GPIO][PIN2_DIR_BIT];
      pin2_q <= cfg_q[REG_GPIO][PIN2_SEL_BIT] ? !ready_q :
                cfg_q[REG_GPIO][PIN2_DAT_BIT];
      analog_q <= !sleep_q;
    end
  end

  assign tx_out = tx_q;
  assign conv_start_out = conv_start_q;
  assign analog_on_out = analog_q;
  assign idac_on_out = analog_q;
  assign result_ready_out = ready_q;
  assign pin2_out = pin2_q;
  assign pin2_oe_out = pin2_oe_q;
  assign cfg_out = {cfg_q[4], cfg_q[3], cfg_q[2], cfg_q[1], cfg_q[0]};
endmodule

// ---- verif/adc_uart_command_engine_sva.sv ----
`timescale 1ns/1ps
module engine_sva (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // Watched pins
  input wire logic rx_in,
  input wire logic tx_out,
  input wire logic conv_done_in,
  input wire logic analog_on_out,
  input wire logic idac_on_out,
  input wire logic [8*adc_cmd_pkg::REG_COUNT-1:0] cfg_out,
  input wire logic result_ready_out,
  input wire logic pin2_out,
  input wire logic pin2_oe_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  // Defaults still visible on the first edge after release
  rst_vals_a: assert property ($fell(reset_in) |-> tx_out &&
    cfg_out == '0 && !result_ready_out && analog_on_out && !pin2_oe_out)
    else $error("reset state wrong");
  // Both current sources share the analog switch
  idac_pair_a: assert property (idac_on_out == analog_on_out)
    else $error("current sources and analog differ");
  // A finished conversion is flagged on the next cycle
  ready_set_a: assert property (conv_done_in && clk_en_in |=>
    result_ready_out) else $error("ready not set after result");
  // Selected pin shows ready, low for new data
  pin2_ready_a: assert property (cfg_out[38] && cfg_out[35] &&
    $rose(result_ready_out) |=> !pin2_out && pin2_oe_out)
    else $error("pin 2 not showing ready");
  // Sleeping never touches the registers
  sleep_regs_a: assert property ($fell(analog_on_out) |->
    $stable(cfg_out)) else $error("registers moved on sleep");
  // Each low stretch on the transmit line lasts at least 8 cycles
  tx_bit_a: assert property ($fell(tx_out) |-> !tx_out [*8])
    else $error("short low bit on transmit");
  // Clearing ready means a frame is leaving
  ready_tx_a: assert property ($fell(result_ready_out) |->
    ##[1:6] $fell(tx_out)) else $error("ready cleared without frame");
  // Effects only once the stop bit has been seen high
  cmd_latch_a: assert property ($changed(cfg_out) |->
    $past(rx_in, 3) && $past(rx_in, 6)) else $error("early command effect");
endmodule

bind adc_uart_command_engine engine_sva u_sva (.mclk_in(mclk_in),
  .reset_in(reset_in), .clk_en_in(clk_en_in), .rx_in(rx_in),
  .tx_out(tx_out), .conv_done_in(conv_done_in),
  .analog_on_out(analog_on_out), .idac_on_out(idac_on_out),
  .cfg_out(cfg_out), .result_ready_out(result_ready_out),
  .pin2_out(pin2_out), .pin2_oe_out(pin2_oe_out));

// ---- verif/host_uart.sv ----
`timescale 1ns/1ps
module host_uart #(
  parameter int BIT = 16
) (
  // Clock
  input wire logic mclk_in,
  // Serial lines, named from the device side
  input wire logic tx_in,
  output logic rx_out
);
  logic [7:0] got[$];
  logic [7:0] sh;
  logic busy = 1'b0;

  // Line rests high between frames
  initial rx_out = 1'b1;

  // One frame: low start, LSB first, high stop
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_out <= f[i];
      repeat (BIT) @(posedge mclk_in);
    end
  endtask

  // Mid-bit sampling; a low stop bit drops the byte
  always @(negedge tx_in) begin
    busy = 1'b1;
    repeat (BIT / 2) @(posedge mclk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge mclk_in);
      sh[i] = tx_in;
    end
    repeat (BIT) @(posedge mclk_in);
    if (tx_in === 1'b1) got.push_back(sh);
    busy = 1'b0;
  end
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import adc_cmd_pkg::*;
  localparam int BIT = 16;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic done_in = 1'b0;
  logic [25:0] raw_in = '0;
  logic rx, tx, start, awake, ready, pin2, idac, oe;
  logic en = 1'b1;
  logic [39:0] cfg;
  logic [7:0] b[$];
  int failures = 0;
  int check_count = 0;
  int starts = 0;

  // Short idle timeout keeps the stall case brief
  adc_uart_command_engine #(.RAW_W(26), .TIMEOUT_NORMAL(2000),
    .TIMEOUT_TURBO(4000)) dut (.mclk_in(mclk_in), .reset_in(reset_in),
    .clk_en_in(en), .rx_in(rx), .tx_out(tx), .conv_done_in(done_in),
    .conv_data_in(raw_in), .conv_start_out(start),
    .analog_on_out(awake), .idac_on_out(idac), .cfg_out(cfg),
    .result_ready_out(ready), .pin2_out(pin2), .pin2_oe_out(oe));
  host_uart #(.BIT(BIT)) host (.mclk_in(mclk_in), .tx_in(tx), .rx_out(rx));

  // Clock and a count of start pulses
  initial forever #20 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (start === 1'b1) starts <= starts + 1;

  task automatic final_report();
    if (failures == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string w, input logic [39:0] e, g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  // Collect n bytes; a silent device ends the run
  task automatic get(input int n);
    int t;
    t = 0;
    while (host.got.size() < n && t < 20 * BIT * (n + 1)) begin
      cyc(1);
      t++;
    end
    if (host.got.size() < n) begin
      failures++;
      $display("[ERR] bytes expected %0d seen %0d", n, host.got.size());
      final_report();
    end else begin
      b = host.got;
      host.got.delete();
    end
  endtask
  // Stay silent while the device talks, then sync word and command
  task automatic cmd(input logic [7:0] c);
    int t;
    t = 0;
    while (host.busy && t < 9999) begin
      cyc(1);
      t++;
    end
    if (host.busy) begin
      failures++;
      $display("[ERR] line_free expected 1 seen 0");
      final_report();
    end else begin
      host.send(8'h55);
      host.send(c);
    end
  endtask
  task automatic go(input logic [7:0] c);
    cmd(c);
    cyc(4);
  endtask
  task automatic reg_write_cmd(input logic [2:0] a, input logic [7:0] d);
    cmd({4'h4, a, 1'b0});
    host.send(d);
    cyc(4);
  endtask
  task automatic reg_read_cmd(input logic [2:0] a);
    cmd({4'h2, a, 1'b0});
    get(1);
  endtask
  // One-cycle result pulse, then let pin updates land
  task automatic done(input logic [25:0] r);
    done_in <= 1'b1;
    raw_in <= r;
    cyc(1);
    done_in <= 1'b0;
    cyc(3);
  endtask

  // Write all registers, read back holes and an unknown command
  task automatic s_regs();
    logic [7:0] v[5] = '{8'hA5, 8'h02, 8'h0A, 8'h1C, 8'h48};
    for (int a = 0; a < 5; a++) reg_write_cmd(a[2:0], v[a]);
    chk("cfg", 40'h481C0A02A5, cfg);
    reg_write_cmd(3'h5, 8'hFF);
    go(8'hF0);
    chk("cfg_kept", 40'h481C0A02A5, cfg);
    chk("silent", 0, host.got.size());
    for (int a = 0; a < 8; a++) begin
      reg_read_cmd(a[2:0]);
      chk("reg_read_cmd", a < 5 ? v[a] : 8'h00, b[0]);
    end
  endtask

  // Clipping, manual readout and the ready pin
  task automatic s_convert();
    logic [25:0] r[3] = '{26'h1FFFFFF, 26'h2000000, 26'h3FFFFFF};
    logic [23:0] e[3] = '{24'h7FFFFF, 24'h800000, 24'hFFFFFF};
    int s;
    for (int i = 0; i < 3; i++) begin
      s = starts;
      go(8'h08);
      chk("start", s + 1, starts);
      done(r[i]);
      chk("ready", 1, ready);
      chk("pin2", 0, pin2);
      chk("pin2_oe", 1, oe);
      cyc(60 * BIT);
      chk("quiet", 0, host.got.size());
      reg_read_cmd(3'h2);
      chk("flag", 1, b[0][7]);
      go(8'h10);
      get(3);
      chk("data", e[i], {b[2], b[1], b[0]});
      chk("cleared", 0, ready);
      chk("pin2", 1, pin2);
    end
  endtask

  // A result arriving while the clock enable is low is not taken
  task automatic s_freeze();
    en <= 1'b0;
    done(26'h0000010);
    chk("frozen", 0, ready);
    en <= 1'b1;
    cyc(2);
  endtask

  // Sleep waits for the running conversion and keeps registers
  task automatic s_sleep();
    int s;
    go(8'h08);
    go(8'h02);
    chk("awake", 1, awake);
    done(26'h0);
    chk("asleep", 0, awake);
    chk("idac_off", 0, idac);
    chk("regs", 40'h481C0A02A5, cfg);
    go(8'h08);
    chk("woken", 1, awake);
    s = starts;
    reg_write_cmd(3'h4, 8'h48);
    chk("no_restart", s, starts);
    reg_write_cmd(3'h0, 8'hA5);
    chk("restart", s + 1, starts);
  endtask

  // Unasked frames with counter and each check-byte option
  task automatic s_auto();
    logic [7:0] m[4] = '{8'h40, 8'h10, 8'h20, 8'h50};
    int n[4] = '{4, 6, 5, 8};
    logic [7:0] c0;
    logic [15:0] crc;
    int o;
    reg_write_cmd(3'h3, 8'h01);
    for (int i = 0; i < 4; i++) begin
      reg_write_cmd(3'h2, m[i]);
      done(26'h3FFFFFF - i);
      get(n[i]);
      cyc(30 * BIT);
      chk("extra", 0, host.got.size());
      o = m[i][6];
      chk("data", 24'hFFFFFF - i, {b[o+2], b[o+1], b[o]});
      if (i == 0) c0 = b[0];
      if (i == 3) chk("count", 8'(c0 + 3), b[0]);
      if (m[i][5:4] == 2'b01)
        for (int k = 0; k < o + 3; k++)
          chk("inv", 8'(~b[k]), b[o+3+k]);
      // Reference CRC16 over the payload, high byte sent first
      if (m[i][5:4] == 2'b10) begin
        crc = CRC_INIT;
        for (int k = 0; k < o + 3; k++) begin
          crc = crc ^ {b[k], 8'h00};
          for (int j = 0; j < 8; j++)
            crc = crc[15] ? ((crc << 1) ^ CRC_POLY) : (crc << 1);
        end
        chk("crc", crc, {b[o+3], b[o+4]});
      end
    end
  endtask

  // A stalled command is dropped after the idle limit
  task automatic s_timeout();
    host.send(8'h55);
    cyc(2200);
    host.send(8'h42);
    host.send(8'h08);
    cyc(4);
    chk("stale", 40'h48015002A5, cfg);
    // Stray bytes may have set a long bit time; let that frame run out
    cyc(60 * BIT);
  endtask

  // Reset command clears every register
  task automatic s_reset();
    go(8'h06);
    chk("cleared", 0, cfg);
    cyc(200);
    reg_read_cmd(3'h3);
    chk("reg3", 0, b[0]);
  endtask

  initial begin
    cyc(6);
    reset_in <= 1'b0;
    s_regs();
    s_convert();
    s_freeze();
    s_sleep();
    s_auto();
    s_timeout();
    s_reset();
    final_report();
  end
endmodule
